// [rtl/failsafe_fault_manager.v]
// Purpose: Fault supervision, reload and checksum check for the fail-safe state
// Assumes: Analog comparators arrive as asynchronous digital levels; pwm_on is on pclk
// Notes: APB slave answers with no wait state; NV array answers one cycle after nv_rd
//
// Design decisions made here: the register addresses and register access over APB.
`include "fsf_regs.vh"

module failsafe_fault_manager #(
    parameter CH = 12,
    parameter W = 8,
    parameter CW = 16,
    parameter RETRY_CYCLES = `FSF_RETRY_CYCLES
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Mode, analog fault levels and PWM state
    input wire in_failsafe,
    input wire supply_good,
    input wire ldo_good,
    input wire low_supply,
    input wire ref_fault,
    input wire overtemp,
    input wire [CH-1:0] out_open,
    input wire [CH-1:0] out_short,
    input wire [CH-1:0] pwm_on,
    // Nonvolatile array
    output reg [2:0] nv_addr_q,
    output reg nv_rd_q,
    input wire [W-1:0] nv_rd_data,
    // Outputs
    output reg [CH-1:0] ch_enable_q,
    output reg [CH-1:0] ch_retry_q,
    output reg fault_line_o_q,
    output reg fault_line_oe_q,
    output reg rails_good_q,
    output reg error_flag_q
);

    localparam SW = 5 + 2 * CH;
    localparam ST_IDLE = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_CMP = 2'd2;
    localparam integer DEG_FULL = `FSF_DEGLITCH_CYCLES;
    localparam [CW-1:0] DEG = DEG_FULL[CW-1:0];

    // Three-stage input capture; value taken once stages two and three agree
    wire [SW-1:0] raw = {supply_good, ldo_good, low_supply, ref_fault, overtemp, out_open, out_short};
    reg [SW-1:0] s1_q, s2_q, s3_q, filt_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= {SW{1'b0}};
            s2_q <= {SW{1'b0}};
            s3_q <= {SW{1'b0}};
            filt_q <= {SW{1'b0}};
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
        end
    end
    wire rails_ok = filt_q[SW-1] & filt_q[SW-2];
    wire low_f = filt_q[SW-3];
    wire ref_f = filt_q[SW-4];
    wire ot_f = filt_q[SW-5];
    wire [CH-1:0] open_f = filt_q[2*CH-1:CH];
    wire [CH-1:0] short_f = filt_q[CH-1:0];

    // Configuration shadow of the nonvolatile array
    reg [W-1:0] cfg_q [0:`FSF_NV_WORDS-1];
    wire [15:0] en16 = {cfg_q[`FSF_NV_EN_HI], cfg_q[`FSF_NV_EN_LO]};
    wire [15:0] diag16 = {cfg_q[`FSF_NV_DIAG_HI], cfg_q[`FSF_NV_DIAG_LO]};
    wire [CH-1:0] en = en16[CH-1:0];
    wire [CH-1:0] diag = diag16[CH-1:0];
    wire [W-1:0] mask = cfg_q[`FSF_NV_MASK];
    wire [CW-1:0] win = ({{(CW-W){1'b0}}, cfg_q[`FSF_NV_ODPW]} << `FSF_ODPW_SHIFT) + DEG;

    // Reload sequencer
    reg [1:0] state_q;
    reg fs_d1_q, rd_vld_q, pend_q, chk_q, por_q;
    reg [2:0] rd_idx_q;
    reg [W-1:0] calc_q;
    wire [W-1:0] sum;
    wire fs_entry = in_failsafe & ~fs_d1_q;
    wire feed = rd_vld_q & (rd_idx_q != `FSF_NV_CHK);
    integer i;

    nv_checksum_acc #(.W(W)) u_sum (
        .pclk(pclk),
        .presetn(presetn),
        .clr(fs_entry),
        .en(feed),
        .din(nv_rd_data),
        .sum_q(sum)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            fs_d1_q <= 1'b0;
            rd_vld_q <= 1'b0;
            rd_idx_q <= 3'd0;
            nv_addr_q <= 3'd0;
            nv_rd_q <= 1'b0;
            pend_q <= 1'b0;
            chk_q <= 1'b0;
            calc_q <= `FSF_RST_WORD;
            for (i = 0; i < `FSF_NV_WORDS; i = i + 1) begin
                cfg_q[i] <= `FSF_RST_WORD;
            end
        end else begin
            fs_d1_q <= in_failsafe;
            rd_vld_q <= nv_rd_q;
            rd_idx_q <= nv_addr_q;
            if (rd_vld_q) begin
                cfg_q[rd_idx_q] <= nv_rd_data;
            end
            if (fs_entry) begin
                // Restart even mid-load so the shadow always matches one pass
                state_q <= ST_LOAD;
                nv_addr_q <= 3'd0;
                nv_rd_q <= 1'b1;
                pend_q <= 1'b1;
            end else begin
                case (state_q)
                    ST_LOAD: begin
                        if (nv_addr_q == `FSF_NV_CHK) begin
                            nv_rd_q <= 1'b0;
                        end else begin
                            nv_addr_q <= nv_addr_q + 3'd1;
                        end
                        if (rd_vld_q && rd_idx_q == `FSF_NV_CHK) begin
                            state_q <= ST_CMP;
                        end
                    end
                    ST_CMP: begin
                        calc_q <= sum;
                        chk_q <= (sum != cfg_q[`FSF_NV_CHK]);
                        pend_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Retry period and window
    reg [20:0] period_q;
    reg [CW-1:0] rwin_q;
    reg ract_q;
    wire tick = in_failsafe && (period_q == RETRY_CYCLES - 1);
    wire rend = ract_q && (rwin_q == win + 16'd2);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_q <= 21'd0;
            rwin_q <= {CW{1'b0}};
            ract_q <= 1'b0;
        end else begin
            period_q <= (!in_failsafe || tick) ? 21'd0 : period_q + 21'd1;
            if (tick) begin
                ract_q <= 1'b1;
                rwin_q <= {CW{1'b0}};
            end else if (rend) begin
                ract_q <= 1'b0;
            end else if (ract_q) begin
                rwin_q <= rwin_q + 16'd1;
            end
        end
    end

    // Per channel detection, flags and retry
    reg [CH-1:0] open_q, short_q, seen_q;
    genvar g;
    generate
        for (g = 0; g < CH; g = g + 1) begin : chan
            reg [CW-1:0] on_q;
            wire active = (pwm_on[g] & ch_enable_q[g]) | ch_retry_q[g];
            wire qual = active && en[g] && diag[g] && (on_q >= win);
            wire det_o = qual & open_f[g] & ~low_f;
            wire det_s = qual & short_f[g];
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    on_q <= {CW{1'b0}};
                    open_q[g] <= 1'b0;
                    short_q[g] <= 1'b0;
                    seen_q[g] <= 1'b0;
                    ch_retry_q[g] <= 1'b0;
                end else begin
                    on_q <= !active ? {CW{1'b0}} : (&on_q ? on_q : on_q + 16'd1);
                    if (tick) begin
                        ch_retry_q[g] <= (open_q[g] | short_q[g]) & en[g] & diag[g];
                    end else if (rend) begin
                        ch_retry_q[g] <= 1'b0;
                    end
                    seen_q[g] <= tick ? 1'b0 : (seen_q[g] | (ract_q & (det_o | det_s)));
                    // Detection wins over a clear in the same cycle
                    if (det_o) begin
                        open_q[g] <= 1'b1;
                    end else if ((rend && !seen_q[g]) || !diag[g]) begin
                        open_q[g] <= 1'b0;
                    end
                    if (det_s) begin
                        short_q[g] <= 1'b1;
                    end else if ((rend && !seen_q[g]) || !diag[g]) begin
                        short_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Summary, fault line and channel gating
    wire out_any = |(open_q | short_q);
    wire line_src = (ref_f & ~mask[`FSF_MASK_REF]) | (ot_f & ~mask[`FSF_MASK_OT]) |
                    (chk_q & ~mask[`FSF_MASK_CHK]) | (out_any & ~mask[`FSF_MASK_OUT]);
    wire all_off = ~rails_ok | ref_f | ot_f | chk_q | pend_q;
    wire apb_wr = psel & penable & pready & pwrite;
    wire por_clr = apb_wr && paddr == `FSF_OFS_CTRL && pwdata[`FSF_CTRL_POR_CLR];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_q <= 1'b0;
            rails_good_q <= 1'b0;
            fault_line_o_q <= 1'b0;
            fault_line_oe_q <= 1'b0;
            error_flag_q <= 1'b0;
            ch_enable_q <= {CH{1'b0}};
        end else begin
            // Set wins over software clear
            if (!rails_ok) begin
                por_q <= 1'b1;
            end else if (por_clr) begin
                por_q <= 1'b0;
            end
            rails_good_q <= rails_ok;
            fault_line_o_q <= 1'b0;
            fault_line_oe_q <= ~rails_ok | line_src;
            error_flag_q <= por_q | low_f | line_src;
            ch_enable_q <= all_off ? {CH{1'b0}} : (en & ~open_q & ~short_q);
        end
    end

    // APB slave, zero wait states
    reg [31:0] rd_d;
    reg hit;
    always @* begin
        rd_d = `FSF_RST_DATA;
        hit = 1'b1;
        case (paddr)
            `FSF_OFS_CTRL: rd_d = `FSF_RST_DATA;
            `FSF_OFS_STATUS: rd_d = {24'h000000, rails_good_q, pend_q, error_flag_q, chk_q, ot_f, ref_f, low_f, por_q};
            `FSF_OFS_OPEN: rd_d = {{(32-CH){1'b0}}, open_q};
            `FSF_OFS_SHORT: rd_d = {{(32-CH){1'b0}}, short_q};
            `FSF_OFS_CALC: rd_d = {{(32-W){1'b0}}, calc_q};
            `FSF_OFS_STORED: rd_d = {{(32-W){1'b0}}, cfg_q[`FSF_NV_CHK]};
            default: hit = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `FSF_RST_DATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= (psel && !penable && !pwrite) ? rd_d : `FSF_RST_DATA;
        end
    end

endmodule

// [inc/fsf_regs.vh]
// Purpose: Offsets, field positions, reset values and timing counts of the fail-safe fault manager
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef FSF_REGS_VH
`define FSF_REGS_VH

// Register byte offsets
`define FSF_OFS_CTRL 8'h00
`define FSF_OFS_STATUS 8'h04
`define FSF_OFS_OPEN 8'h08
`define FSF_OFS_SHORT 8'h0C
`define FSF_OFS_CALC 8'h10
`define FSF_OFS_STORED 8'h14

// CTRL fields
`define FSF_CTRL_POR_CLR 0

// STATUS fields
`define FSF_ST_POR 0
`define FSF_ST_LOWSUP 1
`define FSF_ST_REF 2
`define FSF_ST_OT 3
`define FSF_ST_CHK 4
`define FSF_ST_ERR 5
`define FSF_ST_PEND 6
`define FSF_ST_RAILS 7

// Nonvolatile word map
`define FSF_NV_EN_LO 0
`define FSF_NV_EN_HI 1
`define FSF_NV_DIAG_LO 2
`define FSF_NV_DIAG_HI 3
`define FSF_NV_MASK 4
`define FSF_NV_ODPW 5
`define FSF_NV_WORDS 8
`define FSF_NV_CHK (`FSF_NV_WORDS - 1)

// Mask word fields
`define FSF_MASK_OT 0
`define FSF_MASK_REF 1
`define FSF_MASK_CHK 2
`define FSF_MASK_OUT 3

// Reset values
`define FSF_RST_WORD 8'h00
`define FSF_RST_DATA 32'h0000_0000

// Timing
`define FSF_CLK_KHZ 125000
`define FSF_RETRY_MS 10
`define FSF_RETRY_CYCLES (`FSF_RETRY_MS * `FSF_CLK_KHZ)
`define FSF_DEGLITCH_NS 2000
`define FSF_DEGLITCH_CYCLES ((`FSF_DEGLITCH_NS * (`FSF_CLK_KHZ / 1000) + 999) / 1000)
`define FSF_ODPW_SHIFT 3

`endif

// [rtl/nv_checksum_acc.v]
// Purpose: Running checksum over nonvolatile words fed one per cycle
// Assumes: Rotate-left then xor; any fixed algorithm agreed with the programmer works
// Notes: clr has priority over en
module nv_checksum_acc #(
    parameter W = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Data
    input wire clr,
    input wire en,
    input wire [W-1:0] din,
    output reg [W-1:0] sum_q
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_q <= {W{1'b0}};
        end else if (clr) begin
            sum_q <= {W{1'b0}};
        end else if (en) begin
            sum_q <= {sum_q[W-2:0], sum_q[W-1]} ^ din;
        end
    end

endmodule

// [bench/nv_array_model.sv]
// Purpose: Nonvolatile array behind the fault manager
// Assumes: Word answered the cycle after a read strobe
// Notes: Idle data toggles so a stale word is never mistaken
module nv_array_model (
    // Clock
    input wire logic pclk,
    // Read port
    input wire logic nv_rd_q,
    input wire logic [2:0] nv_addr_q,
    output logic [7:0] nv_rd_data,
    // Contents, word 7 is the stored checksum
    input wire logic [63:0] image
);
    timeunit 1ns;
    timeprecision 1ps;
    initial nv_rd_data = 8'h00;
    always @(posedge pclk) begin
        if (nv_rd_q) begin
            nv_rd_data <= image[nv_addr_q*8 +: 8];
        end else begin
            nv_rd_data <= ~nv_rd_data;
        end
    end
endmodule

// [bench/failsafe_fault_manager_properties.sv]
// Purpose: Port-level checks of the fault manager
// Assumes: Async levels seen within 5 edges
// Notes: Bound to every instance
module fsf_checker #(
    parameter CH = 12
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Inputs watched
    input wire psel,
    input wire penable,
    input wire in_failsafe,
    input wire supply_good,
    input wire low_supply,
    input wire overtemp,
    // Outputs watched
    input wire pready,
    input wire [2:0] nv_addr_q,
    input wire nv_rd_q,
    input wire [CH-1:0] ch_enable_q,
    input wire [CH-1:0] ch_retry_q,
    input wire fault_line_o_q,
    input wire fault_line_oe_q,
    input wire rails_good_q,
    input wire error_flag_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_reload_start: assert property ($rose(in_failsafe) |=> nv_rd_q && nv_addr_q == 3'h0)
        else $error("reload did not start at word zero");
    a_addr_step: assert property (nv_rd_q && nv_addr_q != 3'h7 && !$rose(in_failsafe)
        |=> nv_rd_q && nv_addr_q == $past(nv_addr_q) + 3'h1) else $error("reload address skipped");
    a_read_stop: assert property (nv_rd_q && nv_addr_q == 3'h7 && !$rose(in_failsafe) |=> !nv_rd_q)
        else $error("reload ran past last word");
    a_reload_dark: assert property (nv_rd_q |=> ch_enable_q == '0)
        else $error("channel on during reload");
    a_line_low: assert property (fault_line_o_q == 1'b0)
        else $error("fault line driven high");
    a_rails_bad: assert property (!supply_good [*8] |-> fault_line_oe_q && !rails_good_q)
        else $error("undervoltage not reported");
    a_low_flag: assert property (low_supply [*8] |-> error_flag_q)
        else $error("low supply missing from summary");
    a_hot_off: assert property (overtemp [*8] |-> ch_enable_q == '0)
        else $error("channel on while overheated");
    a_retry_dark: assert property ((ch_retry_q & ch_enable_q) == '0)
        else $error("retry pulse on a driven channel");
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    cover property ($rose(in_failsafe));
    cover property ($rose(fault_line_oe_q));
    cover property (|ch_retry_q);
endmodule
bind failsafe_fault_manager fsf_checker #(.CH(CH)) chk (.pclk, .presetn, .psel, .penable, .in_failsafe,
    .supply_good, .low_supply, .overtemp, .pready, .nv_addr_q, .nv_rd_q, .ch_enable_q, .ch_retry_q,
    .fault_line_o_q, .fault_line_oe_q, .rails_good_q, .error_flag_q);

// [bench/failsafe_fault_manager_tb_top.sv]
// Purpose: Directed tests of the fault manager over APB
// Assumes: Short retry period so retries fit the run
// Notes: Levels driven by non-blocking assignment at rising edges
module failsafe_fault_manager_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, nv_rd_q, fault_line_oe_q, rails_good_q, error_flag_q;
    logic in_failsafe = 1'b0, low_supply = 1'b0, saw_retry = 1'b0;
    logic [1:0] rails = 2'h3, hot = 2'h0;
    logic [11:0] out_open = 12'h000, out_short = 12'h000, pwm_on = 12'hFFF, ch_enable_q, ch_retry_q;
    logic [2:0] nv_addr_q;
    logic [7:0] nv_rd_data, exp_chk;
    logic [63:0] img = 64'h0;
    int num_errors = 0, tests_run = 0;
    always #4 pclk = ~pclk;
    always @(posedge pclk) if (|ch_retry_q) saw_retry <= 1'b1;
    // Period kept above the retry window of width word 1, else a retry never ends
    failsafe_fault_manager #(.RETRY_CYCLES(400)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .in_failsafe, .supply_good(rails[0]), .ldo_good(rails[1]),
        .low_supply, .ref_fault(hot[1]), .overtemp(hot[0]), .out_open, .out_short, .pwm_on, .nv_addr_q,
        .nv_rd_q, .nv_rd_data, .ch_enable_q, .ch_retry_q, .fault_line_o_q(), .fault_line_oe_q,
        .rails_good_q, .error_flag_q);
    nv_array_model nv (.pclk, .nv_rd_q, .nv_addr_q, .nv_rd_data, .image(img));
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] x);
        tests_run++;
        if (seen !== x) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, x, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string n);
        apb(1'b0, a, 32'h0);
        check(n, r & m, x);
    endtask
    function automatic logic [7:0] chk_of(input logic [63:0] m);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 7; i++) s = {s[6:0], s[7]} ^ m[8*i +: 8];
        return s;
    endfunction
    // Words: enable FFF, diag 7FF (channel 11 unwatched), width 1
    task automatic load(input logic [7:0] mask, input logic bad);
        logic [63:0] m;
        m = {8'h00, 8'h5A, 8'h01, mask, 8'h07, 8'hFF, 8'h0F, 8'hFF};
        exp_chk = chk_of(m);
        m[63:56] = exp_chk ^ {7'h00, bad};
        img <= m;
        in_failsafe <= 1'b0;
        @(posedge pclk);
        in_failsafe <= 1'b1;
        repeat (20) @(posedge pclk);
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        // Filter starts low, so power-up always leaves the power-on flag set
        rd(8'h04, 32'hFF, 32'hA1, "powerup status");
        apb(1'b1, 8'h00, 32'h1);
        rd(8'h04, 32'hFF, 32'h80, "idle status");
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped error", e, 1'b1);
        check("unmapped data", r, 32'h0);
        load(8'h00, 1'b0);
        rd(8'h10, 32'hFF, exp_chk, "computed sum");
        rd(8'h14, 32'hFF, exp_chk, "stored sum");
        rd(8'h04, 32'h70, 32'h00, "sum match");
        check("reload enables", ch_enable_q, 12'hFFF);
        load(8'h00, 1'b1);
        rd(8'h04, 32'h30, 32'h30, "sum mismatch");
        check("mismatch off", {fault_line_oe_q, ch_enable_q}, 13'h1000);
        load(8'h04, 1'b1);
        rd(8'h04, 32'h30, 32'h10, "masked mismatch");
        check("masked line", {fault_line_oe_q, ch_enable_q}, 13'h0000);
        load(8'h00, 1'b0);
        rd(8'h04, 32'h30, 32'h00, "sum recovered");
        for (int k = 0; k < 2; k++) begin
            hot <= 2'h1 << k;
            repeat (8) @(posedge pclk);
            rd(8'h04, 32'h2C, 32'h20 | (32'h8 >> k), "fault flag");
            check("fault off", {fault_line_oe_q, ch_enable_q}, 13'h1000);
            hot <= 2'h0;
            repeat (8) @(posedge pclk);
            rd(8'h04, 32'h2C, 32'h00, "fault cleared");
            check("fault back", {fault_line_oe_q, ch_enable_q}, 13'h0FFF);
        end
        load(8'h0B, 1'b0);
        hot <= 2'h3;
        repeat (8) @(posedge pclk);
        rd(8'h04, 32'h2C, 32'h0C, "masked faults");
        check("masked off", {fault_line_oe_q, ch_enable_q}, 13'h0000);
        hot <= 2'h0;
        load(8'h00, 1'b0);
        low_supply <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(8'h04, 32'h22, 32'h22, "low supply");
        check("low no line", fault_line_oe_q, 1'b0);
        low_supply <= 1'b0;
        repeat (8) @(posedge pclk);
        rd(8'h04, 32'h22, 32'h00, "low cleared");
        out_open <= 12'h801;
        out_short <= 12'h002;
        // Pulses shorter than width plus deglitch must not flag
        for (int k = 0; k < 3; k++) begin
            pwm_on <= 12'h000;
            @(posedge pclk);
            pwm_on <= 12'hFFF;
            repeat (100) @(posedge pclk);
        end
        rd(8'h08, 32'hFFF, 32'h000, "short pulse open");
        rd(8'h0C, 32'hFFF, 32'h000, "short pulse short");
        repeat (400) @(posedge pclk);
        rd(8'h08, 32'hFFF, 32'h001, "open flags");
        rd(8'h0C, 32'hFFF, 32'h002, "short flags");
        check("failed off", {fault_line_oe_q, ch_enable_q}, 13'h1FFC);
        out_open <= 12'h000;
        out_short <= 12'h000;
        repeat (1200) @(posedge pclk);
        rd(8'h08, 32'hFFF, 32'h000, "open retried");
        rd(8'h0C, 32'hFFF, 32'h000, "short retried");
        check("retry seen", {saw_retry, fault_line_oe_q, ch_enable_q}, 14'h2FFF);
        for (int k = 0; k < 2; k++) begin
            rails <= ~(2'h1 << k);
            repeat (8) @(posedge pclk);
            check("rails bad", {rails_good_q, fault_line_oe_q}, 2'h1);
            rails <= 2'h3;
            repeat (8) @(posedge pclk);
            rd(8'h04, 32'h81, 32'h81, "powerup flag");
            apb(1'b1, 8'h00, 32'h1);
            rd(8'h04, 32'h01, 32'h00, "powerup cleared");
        end
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end
endmodule
